// >>> shared/aio_cfg_pkg.sv
// Constants and carrier types for the analog channel parameter register set
// Summary of operation
// - Feature bit 0: input user scaling, reset 0
// - Feature bit 1: input factory scaling, reset 1
// - Feature bit 2: input watchdog, reset 1
// - Feature bit 3: input alternate format, reset 0
// - Feature bit 8: output user scaling, reset 0
// - Feature bit 9: output factory scaling, reset 1
// - Feature bit 10: output watchdog, reset 1
// - Feature bit 11: output alternate format, reset 0
// - Feature bit 12: user power-on value, reset 0
// - Power-on value register, reset zero
// - Input user offset register, reset zero
// - Input user gain, reset 256 means unity
// - Output user offset register, reset zero
// - Output user gain, reset 256 means unity
// - Status byte, input word; control byte, output word
// - Control bit 7 selects register access; bit 6 writes
package aio_cfg_pkg;

  localparam int          DATA_W        = 16;
  localparam int          BYTE_W        = 8;
  localparam int          REGNUM_W      = 6;

  localparam logic [5:0]  REG_FEATURE   = 6'h20;
  localparam logic [5:0]  REG_IN_OFS    = 6'h21;
  localparam logic [5:0]  REG_IN_GAIN   = 6'h22;
  localparam logic [5:0]  REG_OUT_PON   = 6'h23;
  localparam logic [5:0]  REG_OUT_OFS   = 6'h24;
  localparam logic [5:0]  REG_OUT_GAIN  = 6'h25;

  localparam int          CB_ACCESS_BIT = 7;
  localparam int          CB_WRITE_BIT  = 6;

  localparam int          FB_IN_USER    = 0;
  localparam int          FB_IN_FACT    = 1;
  localparam int          FB_IN_WDOG    = 2;
  localparam int          FB_IN_ALT     = 3;
  localparam int          FB_OUT_USER   = 8;
  localparam int          FB_OUT_FACT   = 9;
  localparam int          FB_OUT_WDOG   = 10;
  localparam int          FB_OUT_ALT    = 11;
  localparam int          FB_OUT_PON    = 12;

  localparam logic [15:0] FEATURE_RST   = 16'h0606;
  localparam logic [15:0] FEATURE_MASK  = 16'h1F0F;
  localparam logic [15:0] OFFSET_RST    = 16'h0000;
  localparam logic [15:0] GAIN_RST      = 16'h0100;
  localparam logic [15:0] PON_RST       = 16'h0000;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  // Decoded feature controls
  typedef struct packed {
    logic in_user;
    logic in_fact;
    logic in_wdog;
    logic in_alt;
    logic out_user;
    logic out_fact;
    logic out_wdog;
    logic out_alt;
    logic out_pon;
  } feature_t;

  // User scaling words and power-on value of one channel
  typedef struct packed {
    logic [15:0] in_ofs;
    logic [15:0] in_gain;
    logic [15:0] out_pon;
    logic [15:0] out_ofs;
    logic [15:0] out_gain;
  } scale_t;

  // Process image toward the controller
  typedef struct packed {
    logic [7:0]  status_byte;
    logic [15:0] in_word;
  } image_in_t;

  // Process image from the controller
  typedef struct packed {
    logic [7:0]  control_byte;
    logic [15:0] out_word;
  } image_out_t;

endpackage

// >>> rtl/aio_param_regs.sv
// Parameter register storage of one channel
`timescale 1ns/10ps
module aio_param_regs #(
  parameter int W = aio_cfg_pkg::DATA_W
) (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      ce,
  input  wire logic                      wr_en,
  input  wire logic [5:0]                wr_num,
  input  wire logic [W-1:0]              wr_data,
  input  wire logic [5:0]                rd_num,
  output logic      [W-1:0]              rd_data,
  output logic                           rd_hit,
  output aio_cfg_pkg::feature_t          feature,
  output aio_cfg_pkg::scale_t            scale
);

  typedef struct packed {
    logic [15:0] feat;
    logic [15:0] in_ofs;
    logic [15:0] in_gain;
    logic [15:0] out_pon;
    logic [15:0] out_ofs;
    logic [15:0] out_gain;
  } regs_t;

  regs_t state_r;
  regs_t state_nxt;

  localparam regs_t REGS_RST = '{
    feat:     aio_cfg_pkg::FEATURE_RST,
    in_ofs:   aio_cfg_pkg::OFFSET_RST,
    in_gain:  aio_cfg_pkg::GAIN_RST,
    out_pon:  aio_cfg_pkg::PON_RST,
    out_ofs:  aio_cfg_pkg::OFFSET_RST,
    out_gain: aio_cfg_pkg::GAIN_RST
  };

  ////////////////////////////////////////////////////////////////////////////
  // Write path
  always_comb begin
    state_nxt = state_r;
    if (wr_en) begin
      unique case (wr_num)
        aio_cfg_pkg::REG_FEATURE:  state_nxt.feat = wr_data & aio_cfg_pkg::FEATURE_MASK;
        aio_cfg_pkg::REG_IN_OFS:   state_nxt.in_ofs = wr_data;
        aio_cfg_pkg::REG_IN_GAIN:  state_nxt.in_gain = wr_data;
        aio_cfg_pkg::REG_OUT_PON:  state_nxt.out_pon = wr_data;
        aio_cfg_pkg::REG_OUT_OFS:  state_nxt.out_ofs = wr_data;
        aio_cfg_pkg::REG_OUT_GAIN: state_nxt.out_gain = wr_data;
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= REGS_RST;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, 16-bit words
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = aio_cfg_pkg::WORD_ZERO;
    unique case (rd_num)
      aio_cfg_pkg::REG_FEATURE:  rd_data = state_r.feat;
      aio_cfg_pkg::REG_IN_OFS:   rd_data = state_r.in_ofs;
      aio_cfg_pkg::REG_IN_GAIN:  rd_data = state_r.in_gain;
      aio_cfg_pkg::REG_OUT_PON:  rd_data = state_r.out_pon;
      aio_cfg_pkg::REG_OUT_OFS:  rd_data = state_r.out_ofs;
      aio_cfg_pkg::REG_OUT_GAIN: rd_data = state_r.out_gain;
      default: rd_hit = 1'b0;
    endcase
  end

  assign feature.in_user  = state_r.feat[aio_cfg_pkg::FB_IN_USER];
  assign feature.in_fact  = state_r.feat[aio_cfg_pkg::FB_IN_FACT];
  assign feature.in_wdog  = state_r.feat[aio_cfg_pkg::FB_IN_WDOG];
  assign feature.in_alt   = state_r.feat[aio_cfg_pkg::FB_IN_ALT];
  assign feature.out_user = state_r.feat[aio_cfg_pkg::FB_OUT_USER];
  assign feature.out_fact = state_r.feat[aio_cfg_pkg::FB_OUT_FACT];
  assign feature.out_wdog = state_r.feat[aio_cfg_pkg::FB_OUT_WDOG];
  assign feature.out_alt  = state_r.feat[aio_cfg_pkg::FB_OUT_ALT];
  assign feature.out_pon  = state_r.feat[aio_cfg_pkg::FB_OUT_PON];
  assign scale.in_ofs     = state_r.in_ofs;
  assign scale.in_gain    = state_r.in_gain;
  assign scale.out_pon    = state_r.out_pon;
  assign scale.out_ofs    = state_r.out_ofs;
  assign scale.out_gain   = state_r.out_gain;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  reset_values_a: assert property (@(posedge clk_sys) $rose(nrst) |->
    state_r.feat == aio_cfg_pkg::FEATURE_RST && state_r.in_gain == aio_cfg_pkg::GAIN_RST)
    else $error("Parameter reset values wrong");

  unity_gain_a: assert property (@(posedge clk_sys) $rose(nrst) |->
    state_r.out_gain == aio_cfg_pkg::GAIN_RST && state_r.out_pon == aio_cfg_pkg::PON_RST)
    else $error("Output gain or power-on value reset wrong");

endmodule

// >>> rtl/aio_channel_cfg.sv
// Channel process image and register communication for the analog terminal
`timescale 1ns/10ps
module aio_channel_cfg (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      ce,
  input  aio_cfg_pkg::image_out_t        image_out,
  input  wire logic [15:0]               channel_sample_word,
  input  wire logic [5:0]                channel_flags,
  output aio_cfg_pkg::image_in_t         image_in,
  output logic      [15:0]               channel_drive_word,
  output logic                           parameter_access_select,
  output aio_cfg_pkg::feature_t          feature,
  output aio_cfg_pkg::scale_t            scale
);

  typedef struct packed {
    logic [7:0]  status_byte;
    logic [15:0] in_word;
    logic [15:0] drive_word;
    logic        access;
  } ch_state_t;

  ch_state_t state_r;
  ch_state_t state_nxt;

  logic [7:0]  channel_control_byte;
  logic [15:0] channel_output_word;
  logic        req_access;
  logic        req_write;
  logic [5:0]  req_num;
  logic        wr_en;
  logic [15:0] rd_data;
  logic        rd_hit;

  function automatic logic [7:0] ack_byte(input logic wr, input logic [5:0] num);
    ack_byte = {1'b1, wr, num};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control byte decode
  assign channel_control_byte = image_out.control_byte;
  assign channel_output_word  = image_out.out_word;
  assign req_access = channel_control_byte[aio_cfg_pkg::CB_ACCESS_BIT];
  assign req_write  = channel_control_byte[aio_cfg_pkg::CB_WRITE_BIT];
  assign req_num    = channel_control_byte[aio_cfg_pkg::REGNUM_W-1:0];
  assign wr_en      = req_access && req_write;

  aio_param_regs #(
    .W(aio_cfg_pkg::DATA_W)
  ) u_regs (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .wr_en   (wr_en),
    .wr_num  (req_num),
    .wr_data (channel_output_word),
    .rd_num  (req_num),
    .rd_data (rd_data),
    .rd_hit  (rd_hit),
    .feature (feature),
    .scale   (scale)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status byte and input word
  always_comb begin
    state_nxt        = state_r;
    state_nxt.access = req_access;
    if (req_access) begin
      state_nxt.status_byte = ack_byte(req_write, req_num);
      state_nxt.in_word     = (req_write || !rd_hit) ? aio_cfg_pkg::WORD_ZERO : rd_data;
    end else begin
      state_nxt.status_byte = {2'b00, channel_flags};
      state_nxt.in_word     = channel_sample_word;
      state_nxt.drive_word  = channel_output_word;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= '{status_byte: aio_cfg_pkg::BYTE_ZERO, in_word: aio_cfg_pkg::WORD_ZERO,
                   drive_word: aio_cfg_pkg::WORD_ZERO, access: 1'b0};
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign image_in.status_byte  = state_r.status_byte;
  assign image_in.in_word      = state_r.in_word;
  assign channel_drive_word    = state_r.drive_word;
  assign parameter_access_select = state_r.access;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence reg_req_s;
    ce && req_access;
  endsequence

  sequence ack_s;
    image_in.status_byte == {1'b1, $past(req_write), $past(req_num)};
  endsequence

  reg_ack_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_req_s |=> ack_s)
    else $error("Register access not acknowledged");

  proc_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && !req_access |=> !image_in.status_byte[aio_cfg_pkg::CB_ACCESS_BIT]
      && image_in.in_word == $past(channel_sample_word))
    else $error("Process data mode image wrong");

  write_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && wr_en && req_num == aio_cfg_pkg::REG_IN_OFS ##1
    ce && req_access && !req_write && req_num == aio_cfg_pkg::REG_IN_OFS |=>
    image_in.in_word == $past(channel_output_word, 2))
    else $error("Input offset not stored");

  feature_mask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && wr_en && req_num == aio_cfg_pkg::REG_FEATURE |=>
    feature.out_pon == $past(channel_output_word[aio_cfg_pkg::FB_OUT_PON])
    && feature.in_user == $past(channel_output_word[aio_cfg_pkg::FB_IN_USER]))
    else $error("Feature bits not updated");

  freeze_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ce |=> $stable(image_in) && $stable(feature))
    else $error("State changed with enable low");

  reset_feature_a: assert property (@(posedge clk_sys) $rose(nrst) |->
    !feature.in_user && feature.in_fact && feature.in_wdog && !feature.in_alt
    && !feature.out_user && feature.out_fact && feature.out_wdog && !feature.out_alt
    && !feature.out_pon)
    else $error("Feature reset wrong");

endmodule

// >>> tb/aio_coupler_model.sv
// Coupler model exchanging control byte, output word and replies with one channel
`timescale 1ns/10ps
module aio_coupler_model (
  input  wire logic               clk_sys,
  input  aio_cfg_pkg::image_in_t  image_in,
  output aio_cfg_pkg::image_out_t image_out
);
  initial begin
    image_out = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One exchange: set after a falling edge, taken at the rising edge
  task automatic xfer(input logic [7:0] ctrl, input logic [15:0] word,
                      output aio_cfg_pkg::image_in_t rsp);
    @(negedge clk_sys);
    image_out.control_byte = ctrl;
    image_out.out_word     = word;
    @(posedge clk_sys);
    #1;
    rsp = image_in;
  endtask
endmodule

// >>> tb/analog_io_channel_config_tb_top.sv
// Self-checking bench for one analog channel parameter register set
`timescale 1ns/10ps
module analog_io_channel_config_tb_top;
  logic                    clk_sys;
  logic                    nrst;
  logic                    ce;
  logic [15:0]             channel_sample_word;
  logic [5:0]              channel_flags;
  aio_cfg_pkg::image_out_t image_out;
  aio_cfg_pkg::image_in_t  image_in;
  aio_cfg_pkg::image_in_t  rsp;
  aio_cfg_pkg::image_in_t  prev;
  logic [15:0]             channel_drive_word;
  logic                    parameter_access_select;
  aio_cfg_pkg::feature_t   feature;
  aio_cfg_pkg::scale_t     scale;
  logic [15:0]             shadow [6];
  logic [15:0]             d;
  logic [5:0]              n;
  int                      k;
  int                      seed;
  int                      failures;
  int                      n_compared;

  aio_channel_cfg dut (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .image_out(image_out),
    .channel_sample_word(channel_sample_word), .channel_flags(channel_flags),
    .image_in(image_in), .channel_drive_word(channel_drive_word),
    .parameter_access_select(parameter_access_select), .feature(feature), .scale(scale)
  );
  aio_coupler_model model (.clk_sys(clk_sys), .image_in(image_in), .image_out(image_out));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] exp_feat(input logic [15:0] f);
    return {f[0], f[1], f[2], f[3], f[8], f[9], f[10], f[11], f[12]};
  endfunction
  function automatic logic [15:0] exp_mask(input int i, input logic [15:0] v);
    return (i == 0) ? (v & 16'h1F0F) : v;
  endfunction
  function automatic logic [15:0] exp_rst(input int i);
    case (i)
      0:       return 16'h0606;
      2, 5:    return 16'h0100;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reg_wr(input logic [5:0] r, input logic [15:0] v);
    model.xfer({2'b11, r}, v, rsp);
    check({rsp.status_byte, rsp.in_word}, {2'b11, r, 16'h0000});
  endtask
  task automatic reg_rd(input logic [5:0] r, input logic [15:0] e);
    model.xfer({2'b10, r}, 16'h0000, rsp);
    check({rsp.status_byte, rsp.in_word}, {2'b10, r, e});
    check(parameter_access_select, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    failures++;
    print_verdict();
  end

  initial begin
    seed = 66762;
    failures = 0;
    n_compared = 0;
    nrst = 1'b0;
    ce = 1'b1;
    channel_sample_word = 16'h0000;
    channel_flags = 6'h00;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    check(feature, exp_feat(16'h0606));
    check(scale, {16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0100});
    for (k = 0; k < 6; k++) begin
      shadow[k] = exp_rst(k);
      reg_rd(6'h20 + k[5:0], shadow[k]);
    end
    reg_wr(6'h20, 16'hFFFF);
    reg_rd(6'h20, 16'h1F0F);
    check(feature, 9'h1FF);
    reg_wr(6'h20, 16'h0000);
    check(feature, 9'h000);
    shadow[0] = 16'h0000;
    repeat (16) begin
      k = unsigned'($random(seed)) % 6;
      d = 16'($random(seed));
      n = 6'h20 + k[5:0];
      reg_wr(n, d);
      shadow[k] = exp_mask(k, d);
      reg_rd(n, shadow[k]);
    end
    check(feature, exp_feat(shadow[0]));
    check(scale, {shadow[1], shadow[2], shadow[3], shadow[4], shadow[5]});
    reg_wr(6'h05, 16'hBEEF);
    reg_rd(6'h05, 16'h0000);
    reg_rd(6'h1F, 16'h0000);
    reg_rd(6'h26, 16'h0000);
    repeat (8) begin
      @(negedge clk_sys);
      channel_sample_word = 16'($random(seed));
      channel_flags = 6'($random(seed));
      d = 16'($random(seed));
      model.xfer(8'h00, d, rsp);
      check({rsp.status_byte, rsp.in_word}, {2'b00, channel_flags, channel_sample_word});
      check(channel_drive_word, d);
      check(parameter_access_select, 1'b0);
    end
    reg_rd(6'h21, shadow[1]);
    prev = image_in;
    @(negedge clk_sys);
    ce = 1'b0;
    model.xfer({2'b11, 6'h21}, ~shadow[1], rsp);
    model.xfer({2'b10, 6'h22}, 16'h0000, rsp);
    check(rsp, prev);
    @(negedge clk_sys);
    ce = 1'b1;
    reg_rd(6'h21, shadow[1]);
    print_verdict();
  end
endmodule
